// ---- motor_ctrl_defs.vh ----
// Constants for the brushless motor commutation and drive block
`ifndef MOTOR_CTRL_DEFS_VH
`define MOTOR_CTRL_DEFS_VH

`define ADDR_W          12
`define OFF_CTRL        12'h000
`define OFF_STATUS      12'h004

`define CTRL_ENABLE_BIT 0
`define CTRL_BRAKE_BIT  1
`define CTRL_RESET      32'h00000001

`define ST_STEP_LSB     0
`define ST_STEP_MSB     2
`define ST_VALID_BIT    3
`define ST_PWM_BIT      4
`define ST_CS_BIT       5
`define ST_UV_BIT       6
`define ST_FAULT_BIT    7
`define ST_THERM_BIT    8

`define STEP_INVALID    3'h7
`define UV_FILTER       4

`endif

// ---- motor_ctrl.v ----
// Three-phase brushless motor commutation, modulation and fault logic
// Summary of operation
// - Phasing select high decodes sensors as 60 degree, low as 120 degree.
// - Invalid code, brake low: all drives off, fault asserted.
// - Invalid code, brake high: tops off, bottoms on, fault asserted.
// - Valid code, brake and enable high: tops off, bottoms on, no fault.
// - Valid code, brake high, enable low: tops off, bottoms on, fault.
// - Valid code, brake and enable low: tops at 1, bottoms 0, fault.
// - Over-current while running: all bottoms off, fault asserted.
// - Fault and top drive outputs are active low.
// - Ramp discharge sets both modulation and current latches.
// - Ramp above speed command clears the modulation latch.
// - Modulation gates bottom drives only; tops follow commutation.
// - Over-current clears current latch until the next ramp cycle.
// - At most one conduction pulse per oscillator cycle.
// - Fault on invalid code, enable low, over-current, undervoltage, heat.
// - Any undervoltage: fault, tops off, bottoms held low.
// - Supply monitor indications carry hysteresis against chatter.
// - Brake overrides every other input at the drives except undervoltage lockout; fault still follows code, enable and over-current.
// - Thermal shutdown acts exactly like enable low.
//
// Local design decisions: the APB register port and the address map.
`include "motor_ctrl_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module motor_ctrl #(
   parameter UV_FILTER = `UV_FILTER
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        rotor_sensor_a,
   input  wire        rotor_sensor_b,
   input  wire        rotor_sensor_c,
   input  wire        phase_sel_60,
   input  wire        dir_forward,
   input  wire        enable_in,
   input  wire        brake_in,
   input  wire        current_over,
   input  wire        ramp_discharge,
   input  wire        ramp_above_cmd,
   input  wire        uv_logic_supply,
   input  wire        uv_drive_supply,
   input  wire        uv_reference,
   input  wire        thermal_shutdown,
   output reg         top_drive_a_n,
   output reg         top_drive_b_n,
   output reg         top_drive_c_n,
   output reg         bottom_drive_a,
   output reg         bottom_drive_b,
   output reg         bottom_drive_c,
   output reg         fault_n
);

   // Sensor code to step index, 7 when invalid
   function [2:0] decode_step;
      input [2:0] code;
      input       sel60;
      begin
         if (sel60) begin
            case (code)
               3'h4:    decode_step = 3'h0;
               3'h6:    decode_step = 3'h1;
               3'h7:    decode_step = 3'h2;
               3'h3:    decode_step = 3'h3;
               3'h1:    decode_step = 3'h4;
               3'h0:    decode_step = 3'h5;
               default: decode_step = `STEP_INVALID;
            endcase
         end else begin
            case (code)
               3'h4:    decode_step = 3'h0;
               3'h6:    decode_step = 3'h1;
               3'h2:    decode_step = 3'h2;
               3'h3:    decode_step = 3'h3;
               3'h1:    decode_step = 3'h4;
               3'h5:    decode_step = 3'h5;
               default: decode_step = `STEP_INVALID;
            endcase
         end
      end
   endfunction

   // Step to one-hot {c,b,a} phase pairs, {top, bottom}
   function [5:0] step_phases;
      input [2:0] step;
      begin
         case (step)
            3'h0:    step_phases = {3'h1, 3'h4};
            3'h1:    step_phases = {3'h2, 3'h4};
            3'h2:    step_phases = {3'h2, 3'h1};
            3'h3:    step_phases = {3'h4, 3'h1};
            3'h4:    step_phases = {3'h4, 3'h2};
            3'h5:    step_phases = {3'h1, 3'h2};
            default: step_phases = 6'h00;
         endcase
      end
   endfunction

   localparam          CW      = 4;
   localparam   [31:0] UV_FULL = UV_FILTER - 1;
   localparam [CW-1:0] UV_LAST = UV_FULL[CW-1:0];

   // Filter step of one monitor: flip after UV_FILTER disagreeing samples
   function uv_flips;
      input          raw;
      input          held;
      input [CW-1:0] cnt;
      begin
         uv_flips = (raw != held) && (cnt == UV_LAST);
      end
   endfunction

   function [CW-1:0] uv_count;
      input          raw;
      input          held;
      input [CW-1:0] cnt;
      begin
         if (raw == held || uv_flips(raw, held, cnt)) begin
            uv_count = {CW{1'b0}};
         end else begin
            uv_count = cnt + 1'b1;
         end
      end
   endfunction

   reg  [31:0]   ctrl;
   reg  [31:0]   next_prdata;
   reg           pwm_latch;
   reg           cs_latch;
   reg           next_pwm;
   reg           next_cs;
   reg           uv_lock_logic;
   reg           uv_lock_drive;
   reg           uv_lock_ref;
   reg  [CW-1:0] cnt_logic;
   reg  [CW-1:0] cnt_drive;
   reg  [CW-1:0] cnt_ref;
   reg  [2:0]    next_top;
   reg  [2:0]    next_bottom;
   reg           next_fault;
   reg  [5:0]    phases;
   wire [31:0]   status_word;
   wire [2:0]    sensor_code = {rotor_sensor_a, rotor_sensor_b,
                                rotor_sensor_c};
   wire [2:0]    step = decode_step(sensor_code, phase_sel_60);
   wire [5:0]    fwd_phases = step_phases(step);
   wire          code_valid = (step != `STEP_INVALID);
   wire          uv_any = uv_lock_logic | uv_lock_drive | uv_lock_ref;
   wire          brake = brake_in | ctrl[`CTRL_BRAKE_BIT];
   // Heat looks the same as a grounded enable
   wire          run_en = enable_in & ctrl[`CTRL_ENABLE_BIT]
                          & ~thermal_shutdown;
   // Over-current drops bottoms at the next clock edge via the unlatched compare input
   wire          conduct = pwm_latch & cs_latch & ~current_over;
   wire          sel_ctrl = (paddr[11:0] == `OFF_CTRL);
   wire          sel_status = (paddr[11:0] == `OFF_STATUS);
   wire          addr_ok = sel_ctrl | sel_status;
   wire          apb_setup = psel & ~penable;
   wire          apb_rd_setup = apb_setup & ~pwrite;
   wire          apb_wr = psel & penable & pready & pwrite & ~pslverr;

   assign status_word[`ST_STEP_MSB:`ST_STEP_LSB] = step;
   assign status_word[`ST_VALID_BIT] = code_valid;
   assign status_word[`ST_PWM_BIT]   = pwm_latch;
   assign status_word[`ST_CS_BIT]    = cs_latch;
   assign status_word[`ST_UV_BIT]    = uv_any;
   assign status_word[`ST_FAULT_BIT] = ~fault_n;
   assign status_word[`ST_THERM_BIT] = thermal_shutdown;
   assign status_word[31:`ST_THERM_BIT+1] = 23'h000000;

   // Starts locked out, so drives stay off until every supply is seen good
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         uv_lock_logic <= 1'b1;
         cnt_logic     <= {CW{1'b0}};
      end else begin
         cnt_logic <= uv_count(uv_logic_supply, uv_lock_logic,
                               cnt_logic);
         if (uv_flips(uv_logic_supply, uv_lock_logic, cnt_logic)) begin
            uv_lock_logic <= uv_logic_supply;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         uv_lock_drive <= 1'b1;
         cnt_drive     <= {CW{1'b0}};
      end else begin
         cnt_drive <= uv_count(uv_drive_supply, uv_lock_drive,
                               cnt_drive);
         if (uv_flips(uv_drive_supply, uv_lock_drive, cnt_drive)) begin
            uv_lock_drive <= uv_drive_supply;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         uv_lock_ref <= 1'b1;
         cnt_ref     <= {CW{1'b0}};
      end else begin
         cnt_ref <= uv_count(uv_reference, uv_lock_ref,
                             cnt_ref);
         if (uv_flips(uv_reference, uv_lock_ref, cnt_ref)) begin
            uv_lock_ref <= uv_reference;
         end
      end
   end

   // Dual latch; only the ramp discharge can set, so one pulse per cycle
   always @* begin
      next_pwm = pwm_latch;
      next_cs  = cs_latch;
      if (ramp_discharge) begin
         next_pwm = 1'b1;
         next_cs  = 1'b1;
      end else begin
         if (ramp_above_cmd) begin
            next_pwm = 1'b0;
         end
         if (current_over) begin
            next_cs = 1'b0;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_latch <= 1'b0;
      end else begin
         pwm_latch <= next_pwm;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cs_latch <= 1'b0;
      end else begin
         cs_latch <= next_cs;
      end
   end

   // Output selection, highest priority first
   always @* begin
      phases = dir_forward ? fwd_phases
               : {fwd_phases[2:0], fwd_phases[5:3]};
      next_top    = 3'h0;
      next_bottom = 3'h0;
      next_fault  = ~code_valid | ~run_en | current_over
                    | uv_any;
      if (uv_any) begin
         next_top    = 3'h0;
         next_bottom = 3'h0;
      end else if (brake) begin
         next_top    = 3'h0;
         next_bottom = 3'h7;
      end else if (!code_valid) begin
         next_bottom = 3'h0;
      end else if (!run_en) begin
         next_bottom = 3'h0;
      end else begin
         next_top    = phases[5:3];
         next_bottom = phases[2:0] & {3{conduct}};
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         top_drive_a_n <= 1'b1;
         top_drive_b_n <= 1'b1;
         top_drive_c_n <= 1'b1;
      end else begin
         top_drive_a_n <= ~next_top[0];
         top_drive_b_n <= ~next_top[1];
         top_drive_c_n <= ~next_top[2];
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bottom_drive_a <= 1'b0;
         bottom_drive_b <= 1'b0;
         bottom_drive_c <= 1'b0;
      end else begin
         bottom_drive_a <= next_bottom[0];
         bottom_drive_b <= next_bottom[1];
         bottom_drive_c <= next_bottom[2];
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_n <= 1'b0;
      end else begin
         fault_n <= ~next_fault;
      end
   end

   // APB slave: answers in the first access cycle, no wait states
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= apb_setup;
         pslverr <= apb_setup & ~addr_ok;
      end
   end

   always @* begin
      next_prdata = 32'h00000000;
      if (apb_rd_setup) begin
         if (sel_ctrl) begin
            next_prdata = ctrl & 32'h00000003;
         end else if (sel_status) begin
            next_prdata = status_word;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else begin
         prdata <= next_prdata;
      end
   end

   // Unmapped writes are dropped; only the two low bits hold state
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `CTRL_RESET;
      end else if (apb_wr && sel_ctrl) begin
         ctrl <= pwdata & 32'h00000003;
      end
   end

endmodule // motor_ctrl

`default_nettype wire

// ---- motor_ctrl_sva.sv ----
// Assertion checker for the motor commutation block
`timescale 1ns/1ps
`default_nettype none
module motor_ctrl_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic enable_in,
   input wire logic brake_in,
   input wire logic current_over,
   input wire logic thermal_shutdown,
   input wire logic uv_logic_supply,
   input wire logic uv_drive_supply,
   input wire logic uv_reference,
   input wire logic top_drive_a_n,
   input wire logic top_drive_b_n,
   input wire logic top_drive_c_n,
   input wire logic bottom_drive_a,
   input wire logic bottom_drive_b,
   input wire logic bottom_drive_c,
   input wire logic fault_n
);
   wire [2:0] tops = {top_drive_a_n, top_drive_b_n, top_drive_c_n};
   wire [2:0] bots = {bottom_drive_a, bottom_drive_b, bottom_drive_c};
   wire       uv   = uv_logic_supply | uv_drive_supply | uv_reference;
   reg  [3:0] quiet;
   reg  [3:0] hot;
   // Lockout check waits out the default undervoltage filter
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) hot <= 4'h0;
      else if (!uv) hot <= 4'h0;
      else if (hot != 4'hF) hot <= hot + 4'h1;
   end
   // Brake check waits out undervoltage filter lengths up to 15
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) quiet <= 4'h0;
      else if (uv) quiet <= 4'h0;
      else if (quiet != 4'hF) quiet <= quiet + 4'h1;
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   uv_lockout_a: assert property (hot >= 4'h4 |=>
      (tops == 3'h7 && bots == 3'h0 && !fault_n)) else $error("uv drive");
   enable_fault_a: assert property (!enable_in |=> !fault_n)
      else $error("enable low without fault");
   thermal_off_a: assert property (thermal_shutdown && !brake_in |=>
      (tops == 3'h7 && bots == 3'h0)) else $error("thermal drive");
   over_fault_a: assert property (current_over |=> !fault_n)
      else $error("overcurrent without fault");
   over_bottom_a: assert property (current_over && !brake_in |=>
      bots == 3'h0) else $error("overcurrent bottom on");
   brake_all_a: assert property (brake_in && !uv && quiet == 4'hF |=>
      (tops == 3'h7 && bots == 3'h7)) else $error("brake drive");
   step_pair_a: assert property (fault_n && tops != 3'h7 |->
      ($onehot(~tops) && $onehot0(bots) && (~tops & bots) == 3'h0))
      else $error("drive pair");
   ready_setup_a: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("pready timing");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   cover property (pslverr);
   cover property (brake_in ##1 fault_n);
   cover property ($fell(bottom_drive_a | bottom_drive_b | bottom_drive_c));
endmodule // motor_ctrl_sva
bind motor_ctrl motor_ctrl_sva chk (.pclk, .presetn, .psel, .penable,
   .pready, .pslverr, .enable_in, .brake_in, .current_over,
   .thermal_shutdown, .uv_logic_supply, .uv_drive_supply, .uv_reference,
   .top_drive_a_n, .top_drive_b_n, .top_drive_c_n, .bottom_drive_a,
   .bottom_drive_b, .bottom_drive_c, .fault_n);
`default_nettype wire

// ---- hall_model.sv ----
// Rotor position sensor model: step index to sensor levels
`timescale 1ns/1ps
`default_nettype none
module hall_model (
   input  wire logic [2:0] step,
   input  wire logic       sel60,
   output var  logic       a,
   output var  logic       b,
   output var  logic       c
);
   // Steps 6 and 7 give the two codes each phasing rejects
   localparam logic [23:0] T60  = 24'h5417F4;
   localparam logic [23:0] T120 = 24'h1E96B4;
   always_comb begin
      {a, b, c} = sel60 ? T60[step*3 +: 3] : T120[step*3 +: 3];
   end
endmodule // hall_model
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the motor commutation block
`include "motor_ctrl_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        pclk, presetn, psel, penable, pwrite, look;
   logic [31:0] paddr, pwdata, r, q[$];
   logic [31:0] seed = 32'h8ABFF639;
   logic [2:0]  hstep, uv;
   logic        hsel, fwd, en, brake, co, rd, ra, th, sa, sb, sc;
   wire  [31:0] prdata;
   wire         pready, pslverr, ta, tb, tc, ba, bb, bc, fault_n;
   int          fail_count, comparisons, cyc;
   logic [6:0]  bt[4] = '{7'h70, 7'h7E, 7'h33, 7'h7F};
   motor_ctrl #(.UV_FILTER(2)) dut (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .rotor_sensor_a(sa), .rotor_sensor_b(sb), .rotor_sensor_c(sc),
      .phase_sel_60(hsel), .dir_forward(fwd), .enable_in(en),
      .brake_in(brake), .current_over(co), .ramp_discharge(rd),
      .ramp_above_cmd(ra), .uv_logic_supply(uv[0]),
      .uv_drive_supply(uv[1]), .uv_reference(uv[2]),
      .thermal_shutdown(th), .top_drive_a_n(ta), .top_drive_b_n(tb),
      .top_drive_c_n(tc), .bottom_drive_a(ba), .bottom_drive_b(bb),
      .bottom_drive_c(bc), .fault_n);
   hall_model hall (.step(hstep), .sel60(hsel), .a(sa), .b(sb), .c(sc));
   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function logic [6:0] runv(input int s, input logic f);
      logic [2:0] t, b;
      t = 3'h4 >> ((s + 1) / 2 % 3);
      b = 3'h4 >> ((s / 2 + 2) % 3);
      if (!f) {t, b} = {b, t};
      return {~t, b, 1'b1};
   endfunction
   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task complete_run();
      $display("fail_count %0d comparisons %0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Inputs settle through latch and output register before the look
   task go(input logic [6:0] e);
      repeat (4) @(posedge pclk);
      q.push_back({25'h0, e});
      look <= 1'b1;
      @(posedge pclk);
      look <= 1'b0;
   endtask
   task pulse();
      rd <= 1'b1;
      @(posedge pclk);
      rd <= 1'b0;
   endtask
   task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(negedge pclk);
      while (pready !== 1'b1) @(negedge pclk);
      @(posedge pclk);
      {psel, penable} <= 2'b00;
   endtask
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   always @(negedge pclk) begin
      if (look === 1'b1 || (pready === 1'b1 && pwrite === 1'b0))
         check(look ? {25'h0, ta, tb, tc, ba, bb, bc, fault_n} : prdata,
            q.pop_front());
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         complete_run();
      end
   end
   initial begin
      {presetn, psel, penable, pwrite, look, paddr, pwdata} = '0;
      {uv, hstep, hsel, fwd, en, brake, co, rd, ra, th} = 14'h0060;
      @(posedge pclk);
      q.push_back(32'h70);
      look <= 1'b1;
      @(posedge pclk);
      {look, presetn} <= 2'b01;
      pulse();
      for (int i = 0; i < 32; i++) begin
         r = xs();
         {hstep, fwd, hsel} <= {3'(r % 6), r[3], r[4]};
         go(runv(r % 6, r[3]));
      end
      for (int i = 0; i < 8; i++) begin
         {hsel, hstep, brake} <= {i[0], 3'(6 + i[1]), i[2]};
         go(i[2] ? 7'h7E : 7'h70);
      end
      {hstep, hsel, fwd} <= 5'h03;
      for (int i = 0; i < 4; i++) begin
         {en, brake} <= 2'(i);
         go(bt[i]);
      end
      {th, brake} <= 2'b10;
      go(7'h70);
      {th, ra} <= 2'b01;
      go(7'h31);
      ra <= 1'b0;
      go(7'h31);
      pulse();
      go(7'h33);
      co <= 1'b1;
      go(7'h30);
      // Enable dropped after over-current: drives off and fault until enable returns
      {co, en} <= 2'b00;
      go(7'h70);
      en <= 1'b1;
      go(7'h31);
      pulse();
      for (int i = 0; i < 3; i++) begin
         uv <= 3'(1 << i);
         go(7'h70);
         uv <= 3'h0;
         go(7'h33);
      end
      q.push_back(32'h1);
      apb(1'b0, {20'h0, `OFF_CTRL}, 32'h0);
      apb(1'b1, {20'h0, `OFF_CTRL}, 32'h0);
      go(7'h70);
      apb(1'b1, {20'h0, `OFF_CTRL}, 32'h1);
      q.push_back(32'h0);
      apb(1'b0, 32'h10, 32'h0);
      go(7'h33);
      complete_run();
   end
endmodule // testbench
`default_nettype wire
